//--- design/msio_pkg.sv
// package for the motion status and sensor io block
// assumes a single 20 MHz core clock domain
package msio_pkg;
    localparam int          POS_W        = 24;      // signed position width
    localparam int          CLK_HZ       = 20000000;
    localparam int          NUM_ZONES    = 3;
    localparam int          NUM_RESP     = 26;      // echoed input signals
    localparam int          NUM_GEN      = 16;      // general signals
    // register addresses (word index on the plain port)
    localparam logic [4:0]  ADDR_ZONE_BASE = 5'h00; // 6 bound words
    localparam logic [4:0]  ADDR_SENS_CFG  = 5'h06;
    localparam logic [4:0]  ADDR_NET_IN    = 5'h07;
    localparam logic [4:0]  ADDR_NET_OUT   = 5'h08;
    localparam logic [4:0]  ADDR_STATUS    = 5'h09;
    localparam logic [4:0]  ADDR_GEN_POL   = 5'h0a;
    localparam logic [4:0]  ADDR_RESP      = 5'h0b;
    // sensor config field positions
    localparam int          CFG_OT_EN    = 0;
    localparam int          CFG_OT_DECEL = 1;
    localparam int          CFG_LS_NC    = 2;
    localparam int          CFG_MECHANICAL_ORIGIN_SENSOR_NC = 3;
    localparam int          CFG_SLIT_NC  = 4;
    localparam logic [4:0]  CFG_RESET    = 5'h01;   // ot enabled, rest 0
    localparam logic [23:0] BOUND_RESET  = 24'h000000;
    // shaft timing pulse: 50 per rev, 7.2 degrees each
    localparam int          TIM_PER_REV  = 50;
    localparam int          TIM_PULSE_NS = 1000;
    localparam int          TIM_PULSE_CYC =
        (TIM_PULSE_NS * (CLK_HZ / 1000000) + 999) / 1000;
    typedef enum logic [1:0] {
        MSIO_RUN_IDLE   = 2'b00,
        MSIO_RUN_MOVE   = 2'b01,
        MSIO_RUN_STOPIM = 2'b10,
        MSIO_RUN_STOPDC = 2'b11
    } msio_ot_t;
endpackage

//--- design/msio_top.sv
// motion status flags, sensor conditioning and general signal io
// assumes the motion core supplies positions, counts and status levels
// on core_clk; pins pass two flip-flops before use, the main power pin three
//
// Strobed register access and the register addresses were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
module msio_top #(
    parameter int POS_W = msio_pkg::POS_W,
    parameter int NGEN  = msio_pkg::NUM_GEN
) (
    input  wire logic               core_clk,
    input  wire logic               sys_rst,
    // register port
    input  wire logic [4:0]         reg_addr,
    input  wire logic [31:0]        reg_wdata,
    input  wire logic               reg_wr,
    input  wire logic               reg_rd,
    output logic      [31:0]        reg_rdata,
    // motion core status, same clock
    input  wire logic [POS_W-1:0]   cmd_position,
    input  wire logic [POS_W-1:0]   fb_position,
    input  wire logic               load_over_torque,
    input  wire logic               push_active,
    input  wire logic               load_over_push,
    input  wire logic               shaft_step,
    input  wire logic               maint_busy,
    input  wire logic               motor_operating,
    input  wire logic               homing_active,
    // pins
    input  wire logic               main_power_pin,
    input  wire logic               positive_limit_sensor,
    input  wire logic               negative_limit_sensor,
    input  wire logic               mechanical_origin_sensor,
    input  wire logic               slit_sensor,
    input  wire logic [msio_pkg::NUM_RESP-5:0] op_inputs,
    input  wire logic [NGEN-1:0]    direct_input,
    // outputs
    output logic                    torque_limit_flag,
    output logic                    zone_one_flag,
    output logic                    zone_two_flag,
    output logic                    zone_three_flag,
    output logic                    shaft_timing_pulse,
    output logic                    internal_busy_flag,
    output logic                    main_power_flag,
    output logic                    motion_active_flag,
    output logic [msio_pkg::NUM_RESP-1:0] response_out,
    output logic                    limit_home_event,
    output logic                    overtravel_stop,
    output logic                    overtravel_decel,
    output logic                    origin_detect,
    output logic                    slit_detect,
    output logic [NGEN-1:0]         direct_output
);
    // elaboration checks: the zone compare is built for 24 bits only,
    // and one register word carries at most 32 general signals
    if (POS_W != 24) begin : g_bad_pos_w
        $error("msio_top: position width must be 24");
    end
    if (NGEN < 1 || NGEN > 32) begin : g_bad_ngen
        $error("msio_top: NGEN 1 to 32");
    end

    localparam int NP = msio_pkg::NUM_RESP - 4; // operation inputs
    localparam int NS = NP + 4 + NGEN;          // synchronised pins

    // two-stage synchronisers for every pin but the top operation input; stage one is read only here
    logic [NS-1:0] sync_a;
    logic [NS-1:0] sync_b;
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            sync_a <= '0;
            sync_b <= '0;
        end else begin
            sync_a <= {main_power_pin, positive_limit_sensor,
                       negative_limit_sensor, mechanical_origin_sensor,
                       slit_sensor, op_inputs[NP-2:0], direct_input};
            sync_b <= sync_a;
        end
    end
    // main power pin displaces top op bit; kept separate below
    logic main_power_s;
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) main_power_s <= 1'b0;
        else         main_power_s <= sync_b[NS-1];
    end

    logic          plim_s, nlim_s, org_s, slit_s;
    logic [NP-2:0] ops_s;
    logic [NGEN-1:0] din_s;
    assign plim_s = sync_b[NS-2];
    assign nlim_s = sync_b[NS-3];
    assign org_s  = sync_b[NS-4];
    assign slit_s = sync_b[NS-5];
    assign ops_s  = sync_b[NGEN +: NP-1];
    assign din_s  = sync_b[NGEN-1:0];
    // top operation input is a second stop-type pin kept on its own pair
    logic op_top_a, op_top_s;
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            op_top_a <= 1'b0;
            op_top_s <= 1'b0;
        end else begin
            op_top_a <= op_inputs[NP-1];
            op_top_s <= op_top_a;
        end
    end

    // software registers
    logic signed [POS_W-1:0] zone_pos [msio_pkg::NUM_ZONES];
    logic signed [POS_W-1:0] zone_neg [msio_pkg::NUM_ZONES];
    logic [4:0]      sens_cfg;   // overtravel and polarity settings
    logic [NGEN-1:0] net_in;     // network input bits
    logic [NGEN-1:0] gen_pol;    // direct input polarity, 1 inverts

    // zone bound writes: even word positive, odd word negative
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            for (int z = 0; z < msio_pkg::NUM_ZONES; z++) begin
                zone_pos[z] <= msio_pkg::BOUND_RESET;
                zone_neg[z] <= msio_pkg::BOUND_RESET;
            end
        end else if (reg_wr && reg_addr < 5'h06) begin
            if (reg_addr[0]) zone_neg[reg_addr[2:1]] <= reg_wdata[23:0];
            else             zone_pos[reg_addr[2:1]] <= reg_wdata[23:0];
        end
    end

    // configuration writes
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            sens_cfg <= msio_pkg::CFG_RESET;
            net_in   <= '0;
            gen_pol  <= '0;
        end else if (reg_wr) begin
            if (reg_addr == msio_pkg::ADDR_SENS_CFG)
                sens_cfg <= reg_wdata[4:0];
            if (reg_addr == msio_pkg::ADDR_NET_IN)
                net_in <= reg_wdata[NGEN-1:0];
            if (reg_addr == msio_pkg::ADDR_GEN_POL)
                gen_pol <= reg_wdata[NGEN-1:0];
        end
    end

    // zone test, signed compare; used for all three zones
    function automatic logic in_zone(
        input logic signed [23:0] p,
        input logic signed [23:0] pb,
        input logic signed [23:0] nb);
        if (pb < nb)      in_zone = (p <= pb) || (p >= nb);
        else if (pb > nb) in_zone = (p >= nb) && (p <= pb);
        else              in_zone = (p == pb);
    endfunction

    // zone flags follow position continuously, moving or stopped
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            zone_one_flag   <= 1'b0;
            zone_two_flag   <= 1'b0;
            zone_three_flag <= 1'b0;
        end else begin
            zone_one_flag   <= in_zone(cmd_position, zone_pos[0],
                                       zone_neg[0]);
            zone_two_flag   <= in_zone(cmd_position, zone_pos[1],
                                       zone_neg[1]);
            zone_three_flag <= in_zone(fb_position, zone_pos[2],
                                       zone_neg[2]);
        end
    end

    // plain status flags
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            torque_limit_flag  <= 1'b0;
            internal_busy_flag <= 1'b0;
            main_power_flag    <= 1'b0;
            motion_active_flag <= 1'b0;
        end else begin
            // push motion uses its own reduced torque range
            torque_limit_flag  <= push_active ? load_over_push
                                              : load_over_torque;
            internal_busy_flag <= maint_busy;
            main_power_flag    <= main_power_s;
            motion_active_flag <= motor_operating;
        end
    end

    // shaft timing pulse: stretched so slow masters can see it;
    // correct only under the speed ceiling the master keeps
    logic [7:0] tim_cnt;
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            tim_cnt            <= 8'h00;
            shaft_timing_pulse <= 1'b0;
        end else if (shaft_step) begin
            tim_cnt            <= 8'(msio_pkg::TIM_PULSE_CYC - 1);
            shaft_timing_pulse <= 1'b1;
        end else if (tim_cnt != 8'h00) begin
            tim_cnt <= tim_cnt - 8'h01;
        end else begin
            shaft_timing_pulse <= 1'b0;
        end
    end

    // sensor polarity: normally closed contacts read active when open
    logic plim_act, nlim_act, lim_any;
    assign plim_act = plim_s ^ sens_cfg[msio_pkg::CFG_LS_NC];
    assign nlim_act = nlim_s ^ sens_cfg[msio_pkg::CFG_LS_NC];
    assign lim_any  = plim_act || nlim_act;

    // limit handling: homing gets the event, otherwise overtravel
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            limit_home_event <= 1'b0;
            overtravel_stop  <= 1'b0;
            overtravel_decel <= 1'b0;
            origin_detect    <= 1'b0;
            slit_detect      <= 1'b0;
        end else begin
            limit_home_event <= lim_any && homing_active;
            overtravel_stop  <= lim_any && !homing_active
                             && sens_cfg[msio_pkg::CFG_OT_EN];
            overtravel_decel <= sens_cfg[msio_pkg::CFG_OT_DECEL];
            origin_detect    <= org_s
                             ^ sens_cfg[msio_pkg::CFG_MECHANICAL_ORIGIN_SENSOR_NC];
            slit_detect      <= slit_s
                             ^ sens_cfg[msio_pkg::CFG_SLIT_NC];
        end
    end

    // response outputs echo raw input state after polarity, not motion
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) response_out <= '0;
        else response_out <= {plim_act, nlim_act,
                              org_s ^ sens_cfg[msio_pkg::CFG_MECHANICAL_ORIGIN_SENSOR_NC],
                              slit_s ^ sens_cfg[msio_pkg::CFG_SLIT_NC],
                              op_top_s, ops_s};
    end

    // general signals in both directions
    logic [NGEN-1:0] net_out;
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            direct_output <= '0;
            net_out       <= '0;
        end else begin
            direct_output <= net_in;
            net_out       <= din_s ^ gen_pol;
        end
    end

    // read mux, data stands one cycle after the strobe only
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            reg_rdata <= 32'h00000000;
        end else if (!reg_rd) begin
            reg_rdata <= 32'h00000000;
        end else if (reg_addr < 5'h06) begin
            reg_rdata <= reg_addr[0]
                ? 32'(zone_neg[reg_addr[2:1]])
                : 32'(zone_pos[reg_addr[2:1]]);
        end else begin
            unique case (reg_addr)
                msio_pkg::ADDR_SENS_CFG: reg_rdata <= 32'(sens_cfg);
                msio_pkg::ADDR_NET_IN:   reg_rdata <= 32'(net_in);
                msio_pkg::ADDR_NET_OUT:  reg_rdata <= 32'(net_out);
                msio_pkg::ADDR_GEN_POL:  reg_rdata <= 32'(gen_pol);
                msio_pkg::ADDR_STATUS:   reg_rdata <= {24'h000000,
                    motion_active_flag, main_power_flag,
                    internal_busy_flag, shaft_timing_pulse,
                    zone_three_flag, zone_two_flag, zone_one_flag,
                    torque_limit_flag};
                msio_pkg::ADDR_RESP:     reg_rdata <= 32'(response_out);
                default:                 reg_rdata <= 32'h00000000;
            endcase
        end
    end

    // checks
    a_zone_equal: assert property (@(posedge core_clk) disable iff (sys_rst)
        (zone_pos[0] == zone_neg[0] && $stable(zone_pos[0])
         && $stable(cmd_position) && cmd_position != zone_pos[0])
        |=> !zone_one_flag)
        else $error("zone one set off exact match");
    a_zone_inside: assert property (@(posedge core_clk) disable iff (sys_rst)
        ($signed(zone_pos[2]) > $signed(zone_neg[2])
         && $signed(fb_position) >= $signed(zone_neg[2])
         && $signed(fb_position) <= $signed(zone_pos[2]))
        |=> zone_three_flag)
        else $error("zone three missed inside position");
    a_torque_pick: assert property (@(posedge core_clk) disable iff (sys_rst)
        (push_active && !load_over_push) |=> !torque_limit_flag)
        else $error("torque flag ignored push range");
    a_ot_home: assert property (@(posedge core_clk) disable iff (sys_rst)
        homing_active |=> !overtravel_stop)
        else $error("overtravel during homing");
    a_ot_disable: assert property (@(posedge core_clk) disable iff (sys_rst)
        !sens_cfg[msio_pkg::CFG_OT_EN] |=> !overtravel_stop)
        else $error("overtravel while disabled");
    a_tim_pulse: assert property (@(posedge core_clk) disable iff (sys_rst)
        shaft_step |=> shaft_timing_pulse[*2])
        else $error("timing pulse too short");
    a_gen_out: assert property (@(posedge core_clk) disable iff (sys_rst)
        1'b1 |=> direct_output == $past(net_in))
        else $error("direct output not following bit");
    a_busy_flag: assert property (@(posedge core_clk) disable iff (sys_rst)
        maint_busy |=> internal_busy_flag ##0 motion_active_flag
                       == $past(motor_operating))
        else $error("busy flag missed");
    // wrapped window: at or beyond either bound counts as inside
    a_zone_wrap: assert property (@(posedge core_clk) disable iff (sys_rst)
        ($signed(zone_pos[0]) < $signed(zone_neg[0])
         && ($signed(cmd_position) <= $signed(zone_pos[0])
             || $signed(cmd_position) >= $signed(zone_neg[0])))
        |=> zone_one_flag)
        else $error("zone one missed wrapped position");
    // outside homing an enabled limit must stop the motor next cycle
    a_ot_stop: assert property (@(posedge core_clk) disable iff (sys_rst)
        (lim_any && !homing_active && sens_cfg[msio_pkg::CFG_OT_EN])
        |=> overtravel_stop)
        else $error("overtravel missed outside homing");
    // a step opens the pulse, which then stays up long enough for a
    // slow master to see it; a retrigger only lengthens it
    sequence s_tim_start;
        shaft_step;
    endsequence
    sequence s_tim_held;
        shaft_timing_pulse[*8];
    endsequence
    a_tim_hold: assert property (@(posedge core_clk) disable iff (sys_rst)
        s_tim_start |=> s_tim_held)
        else $error("timing pulse dropped early");
endmodule // msio_top
`default_nettype wire

//--- dv/msio_far_model.sv
// far-side model: the motion core pacing shaft steps for the block
// assumes one clock shared with the block; steps only while step_en
`timescale 1ns/100ps
`default_nettype none
module msio_far_model #(
    parameter int STEP_GAP = 40   // cycles between steps, kept slow
) (
    input  wire logic       core_clk,
    input  wire logic       sys_rst,
    input  wire logic       step_en,
    output logic            shaft_step,
    output logic [7:0]      step_index
);
    logic [15:0] gap_cnt;          // spacing between step pulses
    // one pulse per gap keeps the shaft under the speed ceiling
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            gap_cnt    <= '0;
            shaft_step <= 1'b0;
        end else if (step_en && gap_cnt == 16'(STEP_GAP - 1)) begin
            gap_cnt    <= '0;
            shaft_step <= 1'b1;
        end else begin
            gap_cnt    <= step_en ? gap_cnt + 16'h0001 : '0;
            shaft_step <= 1'b0;
        end
    end
    // step position within a revolution, fifty steps a turn
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            step_index <= '0;
        end else if (shaft_step) begin
            step_index <= (step_index == 8'h31) ? 8'h00 : step_index + 8'h01;
        end
    end
endmodule // msio_far_model
`default_nettype wire

//--- dv/msio_top_tb.sv
// self-checking bench for the motion status and sensor io block
// assumes the register port answers reads one cycle after the strobe
`timescale 1ns/100ps
`default_nettype none
module msio_top_tb;
    localparam int MAX_CYC = 20000;    // far above the planned run
    logic        core_clk, sys_rst, reg_wr, reg_rd, step_en;
    logic [4:0]  reg_addr;
    logic [31:0] reg_wdata, reg_rdata, rd_val;
    logic [23:0] cmd_position, fb_position;
    logic        load_over_torque, push_active, load_over_push, shaft_step;
    logic        maint_busy, motor_operating, homing_active, main_power_pin;
    logic        positive_limit_sensor, negative_limit_sensor;
    logic        mechanical_origin_sensor, slit_sensor;
    logic [21:0] op_inputs;
    logic [15:0] direct_input, direct_output;
    logic        torque_limit_flag, zone_one_flag, zone_two_flag;
    logic        zone_three_flag, shaft_timing_pulse, internal_busy_flag;
    logic        main_power_flag, motion_active_flag, limit_home_event;
    logic        overtravel_stop, overtravel_decel, origin_detect;
    logic        slit_detect, tim_last;
    logic [25:0] response_out;
    int          n_errors, check_count, cyc, n_steps, n_rise, n_high;
    msio_top dut (.core_clk(core_clk), .sys_rst(sys_rst),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .cmd_position(cmd_position), .fb_position(fb_position),
        .load_over_torque(load_over_torque), .push_active(push_active),
        .load_over_push(load_over_push), .shaft_step(shaft_step),
        .maint_busy(maint_busy), .motor_operating(motor_operating),
        .homing_active(homing_active), .main_power_pin(main_power_pin),
        .positive_limit_sensor(positive_limit_sensor),
        .negative_limit_sensor(negative_limit_sensor),
        .mechanical_origin_sensor(mechanical_origin_sensor),
        .slit_sensor(slit_sensor), .op_inputs(op_inputs),
        .direct_input(direct_input), .torque_limit_flag(torque_limit_flag),
        .zone_one_flag(zone_one_flag), .zone_two_flag(zone_two_flag),
        .zone_three_flag(zone_three_flag),
        .shaft_timing_pulse(shaft_timing_pulse),
        .internal_busy_flag(internal_busy_flag),
        .main_power_flag(main_power_flag),
        .motion_active_flag(motion_active_flag),
        .response_out(response_out), .limit_home_event(limit_home_event),
        .overtravel_stop(overtravel_stop),
        .overtravel_decel(overtravel_decel), .origin_detect(origin_detect),
        .slit_detect(slit_detect), .direct_output(direct_output));
    msio_far_model far (.core_clk(core_clk), .sys_rst(sys_rst),
        .step_en(step_en), .shaft_step(shaft_step), .step_index());
    // 50 ns clock
    always #25 core_clk = ~core_clk;
    // hang guard plus counting of steps and timing pulse shape
    always @(posedge core_clk) begin
        cyc++;
        n_steps += shaft_step;
        n_rise += (shaft_timing_pulse && !tim_last);
        n_high += shaft_timing_pulse;
        tim_last = shaft_timing_pulse;
        if (cyc == MAX_CYC) begin
            n_errors++;
            finish_test();
        end
    end
    task automatic finish_test();
        if (n_errors == 0 && check_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_errors++;
            $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // waits, then steps past the edge so outputs have settled
    task automatic wait_cyc(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask
    task automatic wr(input logic [4:0] a, input logic [31:0] d);
        @(posedge core_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask
    // read data stands only in the cycle after the strobe
    task automatic rd(input logic [4:0] a);
        @(posedge core_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1 rd_val = reg_rdata;
    endtask
    // one zone-one case: bounds, command position, expected flag
    task automatic zcase(input int pb, nb, p, input logic e);
        wr(5'h00, 32'(pb));
        wr(5'h01, 32'(nb));
        @(posedge core_clk);
        cmd_position <= 24'(p);
        wait_cyc(3);
        check(zone_one_flag, e);
    endtask
    task automatic t_reset_values();
        for (int i = 0; i < 6; i++) begin
            rd(5'(i));
            check(rd_val, 32'h0);
        end
        rd(msio_pkg::ADDR_SENS_CFG);
        check(rd_val, 32'h01);
        rd(5'h1f);
        check(rd_val, 32'h0);
        check({zone_one_flag, zone_two_flag, zone_three_flag}, 3'h7);
    endtask
    task automatic t_zones();
        zcase(100, -100, -100, 1'b1);
        zcase(100, -100, 100, 1'b1);
        zcase(100, -100, 101, 1'b0);
        zcase(100, -100, -101, 1'b0);
        zcase(-50, 50, -50, 1'b1);
        zcase(-50, 50, 50, 1'b1);
        zcase(-50, 50, 0, 1'b0);
        zcase(-8388608, 8388607, 8388607, 1'b1);
        zcase(-7, -7, -7, 1'b1);
        zcase(-7, -7, -6, 1'b0);
        rd(5'h01);
        check(rd_val, 32'hffff_fff9);
    endtask
    task automatic t_zone_source();
        zcase(0, 0, 0, 1'b1);
        wr(5'h02, 32'h5);
        wr(5'h03, 32'h5);
        wr(5'h04, 32'ha);
        wr(5'h05, 32'ha);
        @(posedge core_clk);
        fb_position <= 24'ha;
        wait_cyc(3);
        check({zone_one_flag, zone_two_flag, zone_three_flag}, 3'h5);
        @(posedge core_clk);
        cmd_position <= 24'h5;
        fb_position <= 24'h0;
        wait_cyc(3);
        check({zone_one_flag, zone_two_flag, zone_three_flag}, 3'h2);
        wr(5'h04, 32'h14);
        wr(5'h05, 32'hffff_ffec);
        wait_cyc(3);
        check(zone_three_flag, 1'b1);
        @(posedge core_clk);
        fb_position <= 24'h15;
        wait_cyc(3);
        check(zone_three_flag, 1'b0);
    endtask
    task automatic t_status();
        @(posedge core_clk);
        load_over_torque <= 1'b1;
        maint_busy <= 1'b1;
        motor_operating <= 1'b1;
        main_power_pin <= 1'b1;
        wait_cyc(6);
        check({torque_limit_flag, internal_busy_flag}, 2'h3);
        check({main_power_flag, motion_active_flag}, 2'h3);
        rd(msio_pkg::ADDR_STATUS);
        check(rd_val & 32'he1, 32'he1);
        @(posedge core_clk);
        load_over_torque <= 1'b0;
        maint_busy <= 1'b0;
        motor_operating <= 1'b0;
        main_power_pin <= 1'b0;
        load_over_push <= 1'b1;
        wait_cyc(6);
        check({torque_limit_flag, internal_busy_flag}, 2'h0);
        check({main_power_flag, motion_active_flag}, 2'h0);
        @(posedge core_clk);
        push_active <= 1'b1;
        wait_cyc(3);
        check(torque_limit_flag, 1'b1);
    endtask
    task automatic t_sensors();
        @(posedge core_clk);
        positive_limit_sensor <= 1'b1;
        wait_cyc(5);
        check({overtravel_stop, overtravel_decel}, 2'h2);
        @(posedge core_clk);
        homing_active <= 1'b1;
        wait_cyc(3);
        check({overtravel_stop, limit_home_event}, 2'h1);
        @(posedge core_clk);
        homing_active <= 1'b0;
        wr(msio_pkg::ADDR_SENS_CFG, 32'h00);
        wait_cyc(3);
        check(overtravel_stop, 1'b0);
        @(posedge core_clk);
        negative_limit_sensor <= 1'b1;
        wr(msio_pkg::ADDR_SENS_CFG, 32'h07);
        wait_cyc(5);
        check({overtravel_stop, overtravel_decel}, 2'h1);
        @(posedge core_clk);
        negative_limit_sensor <= 1'b0;
        mechanical_origin_sensor <= 1'b1;
        slit_sensor <= 1'b1;
        wait_cyc(5);
        check(overtravel_stop, 1'b1);
        check({origin_detect, slit_detect}, 2'h3);
        wr(msio_pkg::ADDR_SENS_CFG, 32'h19);
        wait_cyc(3);
        check({origin_detect, slit_detect}, 2'h0);
        rd(msio_pkg::ADDR_SENS_CFG);
        check(rd_val, 32'h19);
    endtask
    task automatic t_response();
        @(posedge core_clk);
        op_inputs <= 22'h2a5a5c;
        motor_operating <= 1'b0;
        wait_cyc(5);
        check(response_out, {4'h8, 22'h2a5a5c});
        rd(msio_pkg::ADDR_RESP);
        check(rd_val, {6'h0, 4'h8, 22'h2a5a5c});
    endtask
    task automatic t_general();
        wr(msio_pkg::ADDR_NET_IN, 32'h8001);
        wait_cyc(3);
        check(direct_output, 16'h8001);
        wr(msio_pkg::ADDR_NET_IN, 32'h0);
        wait_cyc(3);
        check(direct_output, 16'h0);
        @(posedge core_clk);
        direct_input <= 16'h0080;
        wait_cyc(5);
        rd(msio_pkg::ADDR_NET_OUT);
        check(rd_val, 32'h0080);
        wr(msio_pkg::ADDR_GEN_POL, 32'h0080);
        wait_cyc(3);
        rd(msio_pkg::ADDR_NET_OUT);
        check(rd_val, 32'h0);
    endtask
    task automatic t_timing();
        n_steps = 0;
        n_rise = 0;
        n_high = 0;
        @(posedge core_clk);
        step_en <= 1'b1;
        wait_cyc(200);
        @(posedge core_clk);
        step_en <= 1'b0;
        wait_cyc(60);
        check(n_rise, n_steps);
        check(n_high, n_steps * msio_pkg::TIM_PULSE_CYC);
    endtask
    initial begin
        {core_clk, reg_wr, reg_rd, step_en, tim_last} = '0;
        {reg_addr, reg_wdata, cmd_position, fb_position} = '0;
        {load_over_torque, push_active, load_over_push, maint_busy} = '0;
        {motor_operating, homing_active, main_power_pin} = '0;
        {positive_limit_sensor, negative_limit_sensor} = '0;
        {mechanical_origin_sensor, slit_sensor, op_inputs} = '0;
        {direct_input, n_errors, check_count, cyc} = '0;
        sys_rst = 1'b1;
        repeat (8) @(posedge core_clk);
        sys_rst <= 1'b0;
        wait_cyc(2);
        t_reset_values();
        t_zones();
        t_zone_source();
        t_status();
        t_sensors();
        t_response();
        t_general();
        t_timing();
        finish_test();
    end
endmodule // msio_top_tb
`default_nettype wire
